// file: hw/pll_clock_pkg.sv
package pll_clock_pkg;

	// ****************************************************************
	// register map (byte addresses)
	// ****************************************************************
	localparam logic [7:0] CTRL_OFFSET   = 8'h00;
	localparam logic [7:0] DIVIDE_OFFSET = 8'h04;
	localparam logic [7:0] STATUS_OFFSET = 8'h08;

	// ****************************************************************
	// field positions
	// ****************************************************************
	localparam int AUTO_BIT      = 0;
	localparam int FILTER_BIT    = 1;
	localparam int PLL_ON_BIT    = 2;
	localparam int LOCK_IE_BIT   = 3;
	localparam int BASE_PLL_BIT  = 4;
	localparam int MOD_XTAL_BIT  = 5;
	localparam int MON_EN_BIT    = 6;
	localparam int NO_LIMP_BIT   = 7;
	localparam int REF_DIV_LSB   = 0;
	localparam int MULT_LSB      = 8;
	localparam int SLOW_LSB      = 16;
	localparam int LOCK_BIT      = 0;
	localparam int TRACK_BIT     = 1;
	localparam int LOCK_CHG_BIT  = 2;
	localparam int READY_BIT     = 3;

	// ****************************************************************
	// reset values
	// ****************************************************************
	localparam logic       AUTO_RESET      = 1'b1;
	localparam logic       FILTER_RESET    = 1'b0;
	localparam logic       PLL_ON_RESET    = 1'b1;
	localparam logic       LOCK_IE_RESET   = 1'b0;
	localparam logic       BASE_PLL_RESET  = 1'b0;
	localparam logic       MOD_XTAL_RESET  = 1'b0;
	localparam logic       MON_EN_RESET    = 1'b1;
	localparam logic       NO_LIMP_RESET   = 1'b0;
	localparam logic [2:0] REF_DIV_RESET   = 3'h0;
	localparam logic [5:0] MULT_RESET      = 6'h00;
	localparam logic [5:0] SLOW_RESET      = 6'h01;

	// ****************************************************************
	// timing
	// ****************************************************************
	localparam int          CLK_PERIOD_NS  = 25;
	localparam int          STAB_TIME_NS   = 100000;
	localparam int          STAB_CYCLES_I  =
		(STAB_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [11:0] STAB_CYCLES    = 12'(STAB_CYCLES_I);
	localparam logic [7:0]  LD_WINDOW      = 8'h10;
	localparam logic [7:0]  LOCK_TOL       = 8'h01;
	localparam logic [7:0]  UNLOCK_TOL     = 8'h03;
	localparam logic [7:0]  TRK_TOL        = 8'h02;
	localparam logic [7:0]  UNT_TOL        = 8'h04;
	localparam logic [7:0]  SLOW_STEP      = 8'h04;

	// ****************************************************************
	// carriers
	// ****************************************************************
	typedef struct packed {
		logic base_clock;
		logic cpu_clock;
		logic bus_clock_out;
		logic peripheral;
		logic crystal_derived_clock;
		logic module_clock;
		logic can_clock;
		logic debug_clock;
		logic reference_clock;
		logic feedback_clock;
	} clk_ticks_t;

	typedef struct packed {
		logic       auto_bw;
		logic       acquisition_mode_bit;
		logic       pll_on_bit;
		logic       lock_irq_enable;
		logic       base_pll;
		logic       mod_xtal;
		logic       clock_monitor_enable;
		logic       no_limp_home_bit;
		logic [2:0] ref_div;
		logic [5:0] mult;
		logic [5:0] slow_code;
	} ctrl_t;

	typedef struct packed {
		logic [7:0] cnt;
		logic       tick;
	} div_state_t;

endpackage

// file: hw/tick_divider.sv
`timescale 1ns/1ps
module tick_divider (
	input  wire logic       pclk,
	input  wire logic       presetn,
	input  wire logic       ce,
	input  wire logic       en,
	input  wire logic [7:0] divisor,
	output logic            tick
);
	pll_clock_pkg::div_state_t s;
	pll_clock_pkg::div_state_t next_s;

	// divisor of zero behaves as one
	always_comb begin
		next_s = s;
		next_s.tick = 1'b0;
		if (en) begin
			if (s.cnt + 8'h01 >= divisor) begin
				next_s.cnt = 8'h00;
				next_s.tick = 1'b1;
			end else begin
				next_s.cnt = s.cnt + 8'h01;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s <= '0;
		end else if (ce) begin
			s <= next_s;
		end
	end

	assign tick = s.tick;
endmodule

// file: hw/pll_clock_generator.sv
// The APB interface to the registers and the address map were left to the implementer.
`timescale 1ns/1ps
// Functional notes
// RULE_01 - slow divider divides crystal by 4 to 252 in steps of 4
// RULE_02 - reference divider divides crystal by 1 to 8
// RULE_03 - PLL output equals reference times a factor 1 to 64
// RULE_04 - module clock selects peripheral or crystal-derived clock
// RULE_05 - crystal-derived clock feeds periodic timer, watchdog, stop delay
// RULE_06 - CAN clock selects raw external clock or base clock
// RULE_07 - debug clock selects dedicated debug clock or bus clock
// RULE_08 - PLL keeps running in WAIT
// RULE_09 - PLL suspends in STOP, resumes after stabilisation only if automatic
// RULE_10 - lock detector compares feedback and reference frequencies
// RULE_11 - acquisition bit zero means acquisition; one forces tracking
// RULE_12 - automatic mode: hardware sets and clears acquisition bit by tolerance
// RULE_13 - lock flag read-only, set within lock, cleared outside unlock tolerance
// RULE_14 - with enable set, any lock flag change requests an interrupt
// RULE_15 - software uses PLL as base clock only once locked
// RULE_16 - manual mode keeps lock detection and lock interrupt active
// RULE_17 - manual mode: acquisition bit writable, cleared before PLL on
// RULE_18 - manual mode: software waits acquisition time before tracking
// RULE_19 - reset sets clock monitor enable and PLL on, clears no-limp-home
// RULE_20 - feedback input synchronised before lock and mode decisions
module pll_clock_generator (
	input  wire logic                      pclk,
	input  wire logic                      presetn,
	input  wire logic                      ce,
	input  wire logic                      psel,
	input  wire logic                      penable,
	input  wire logic                      pwrite,
	input  wire logic [7:0]                paddr,
	input  wire logic [31:0]               pwdata,
	output logic      [31:0]               prdata,
	output logic                           pready,
	output logic                           pslverr,
	input  wire logic                      vco_clock,
	input  wire logic                      stop_mode,
	input  wire logic                      wait_mode,
	input  wire logic                      can_clock_sel,
	input  wire logic                      debug_clock_sel,
	input  wire logic                      debug_tick,
	output logic                           pll_run,
	output logic                           filter_tracking,
	output logic      [5:0]                vco_multiplier,
	output logic                           lock_irq,
	output pll_clock_pkg::clk_ticks_t      ticks
);

	// ****************************************************************
	// state
	// ****************************************************************
	typedef struct packed {
		pll_clock_pkg::ctrl_t       ctrl;
		logic                       lock;
		logic                       lock_chg;
		logic [2:0]                 vco_sync;
		logic [7:0]                 fb_cnt;
		logic [7:0]                 win_cnt;
		logic [11:0]                stab_cnt;
		logic                       stopped;
		logic                       bus_phase;
		pll_clock_pkg::clk_ticks_t  tk;
		logic [31:0]                rdata;
		logic                       err;
	} gen_state_t;

	gen_state_t s;
	gen_state_t next_s;

	logic       vco_edge;
	logic       ready;
	logic       run;
	logic       base_tick;
	logic       wr;
	logic       setup;
	logic [7:0] diff;
	logic [7:0] fb_total;
	logic       window_end;
	logic [2:0] div_en;
	logic [7:0] div_val [3];
	logic [2:0] div_tick;

	// ****************************************************************
	// dividers: slow, reference, feedback
	// ****************************************************************
	always_comb begin
		div_en[0]  = 1'b1;
		div_val[0] = (s.ctrl.slow_code == 6'h00) ? pll_clock_pkg::SLOW_STEP
			: 8'({s.ctrl.slow_code, 2'b00});                      // [RULE_01]
		div_en[1]  = run;
		div_val[1] = 8'({5'h00, s.ctrl.ref_div}) + 8'h01;         // [RULE_02]
		div_en[2]  = run & vco_edge;
		div_val[2] = 8'({2'b00, s.ctrl.mult}) + 8'h01;            // [RULE_03]
	end

	genvar gi;
	generate
		for (gi = 0; gi < 3; gi = gi + 1) begin : g_div
			tick_divider u_div (
				.pclk    (pclk),
				.presetn (presetn),
				.ce      (ce),
				.en      (div_en[gi]),
				.divisor (div_val[gi]),
				.tick    (div_tick[gi])
			);
		end
	endgenerate

	// ****************************************************************
	// combinational helpers
	// ****************************************************************
	// only the second and third flops are looked at
	assign vco_edge = s.vco_sync[1] & ~s.vco_sync[2];             // [RULE_20]
	// wait_mode has no effect: the loop stays up in WAIT
	assign run      = s.ctrl.pll_on_bit & ~stop_mode;      // [RULE_08] [RULE_09]
	assign ready    = (s.stab_cnt == 12'h000);
	// crystal tick is every pclk; PLL used only when up and settled
	assign base_tick = (s.ctrl.base_pll & run & ready) ? vco_edge : 1'b1;
	assign setup    = psel & ~penable;
	assign wr       = psel & penable & pwrite;
	assign fb_total = s.fb_cnt + {7'h00, div_tick[2]};
	assign window_end = div_tick[1] && (s.win_cnt == pll_clock_pkg::LD_WINDOW
		- 8'h01);
	assign diff = (fb_total > pll_clock_pkg::LD_WINDOW)
		? fb_total - pll_clock_pkg::LD_WINDOW
		: pll_clock_pkg::LD_WINDOW - fb_total;                    // [RULE_10]

	// ****************************************************************
	// next state
	// ****************************************************************
	always_comb begin
		next_s = s;
		next_s.vco_sync = {s.vco_sync[1:0], vco_clock};              // [RULE_20]

		// derived clock ticks, all registered
		next_s.bus_phase = base_tick ? ~s.bus_phase : s.bus_phase;
		next_s.tk.base_clock      = base_tick;
		next_s.tk.cpu_clock       = base_tick;
		next_s.tk.bus_clock_out   = base_tick & s.bus_phase;
		next_s.tk.peripheral      = base_tick & s.bus_phase;
		next_s.tk.crystal_derived_clock = div_tick[0];              // [RULE_05]
		next_s.tk.module_clock    = s.ctrl.mod_xtal ? div_tick[0]
			: (base_tick & s.bus_phase);                             // [RULE_04]
		next_s.tk.can_clock       = can_clock_sel ? base_tick : 1'b1; // [RULE_06]
		next_s.tk.debug_clock     = debug_clock_sel
			? (base_tick & s.bus_phase) : debug_tick;               // [RULE_07]
		next_s.tk.reference_clock = div_tick[1];
		next_s.tk.feedback_clock  = div_tick[2];

		// stabilisation after power-up of the loop or STOP exit
		if (s.stab_cnt != 12'h000) begin
			next_s.stab_cnt = s.stab_cnt - 12'h001;
		end
		next_s.stopped = stop_mode;
		if (s.stopped && !stop_mode) begin
			next_s.stab_cnt = pll_clock_pkg::STAB_CYCLES;            // [RULE_09]
			if (!s.ctrl.auto_bw) begin
				// manual loop is not restarted; fall back to crystal
				next_s.ctrl.pll_on_bit = 1'b0;                     // [RULE_09]
				next_s.ctrl.base_pll   = 1'b0;
			end
		end

		// lock detector, active in both modes
		if (!run) begin
			next_s.fb_cnt  = 8'h00;
			next_s.win_cnt = 8'h00;
			next_s.lock    = 1'b0;
		end else if (window_end) begin
			next_s.fb_cnt  = 8'h00;
			next_s.win_cnt = 8'h00;
			if (!s.lock && diff <= pll_clock_pkg::LOCK_TOL) begin
				next_s.lock = 1'b1;                        // [RULE_13] [RULE_16]
			end else if (s.lock && diff > pll_clock_pkg::UNLOCK_TOL) begin
				next_s.lock = 1'b0;                                  // [RULE_13]
			end
			if (s.ctrl.auto_bw) begin
				if (diff <= pll_clock_pkg::TRK_TOL) begin
					next_s.ctrl.acquisition_mode_bit = 1'b1;             // [RULE_12]
				end else if (diff > pll_clock_pkg::UNT_TOL) begin
					next_s.ctrl.acquisition_mode_bit = 1'b0;             // [RULE_12]
				end
			end
		end else begin
			if (div_tick[1]) begin
				next_s.win_cnt = s.win_cnt + 8'h01;
			end
			if (div_tick[2] && s.fb_cnt != 8'hFF) begin
				next_s.fb_cnt = fb_total;
			end
		end
		if (s.ctrl.auto_bw && !run) begin
			next_s.ctrl.acquisition_mode_bit = 1'b0;
		end

		// ************************************************************
		// APB access
		// ************************************************************
		if (setup) begin
			next_s.err   = 1'b0;
			next_s.rdata = 32'h0000_0000;
			if (paddr == pll_clock_pkg::CTRL_OFFSET) begin
				next_s.rdata = {24'h000000, s.ctrl.no_limp_home_bit,
					s.ctrl.clock_monitor_enable, s.ctrl.mod_xtal,
					s.ctrl.base_pll, s.ctrl.lock_irq_enable,
					s.ctrl.pll_on_bit, s.ctrl.acquisition_mode_bit,
					s.ctrl.auto_bw};                                  // [RULE_11]
			end else if (paddr == pll_clock_pkg::DIVIDE_OFFSET) begin
				next_s.rdata = {10'h000, s.ctrl.slow_code, 2'b00,
					s.ctrl.mult, 5'h00, s.ctrl.ref_div};
			end else if (paddr == pll_clock_pkg::STATUS_OFFSET) begin
				next_s.rdata = {28'h0000000, ready, s.lock_chg,
					s.ctrl.acquisition_mode_bit, s.lock};
			end else begin
				next_s.err = 1'b1;
			end
		end

		if (wr && paddr == pll_clock_pkg::CTRL_OFFSET) begin
			next_s.ctrl.auto_bw = pwdata[pll_clock_pkg::AUTO_BIT];
			if (!s.ctrl.auto_bw) begin
				next_s.ctrl.acquisition_mode_bit =
					pwdata[pll_clock_pkg::FILTER_BIT];                   // [RULE_17]
			end
			next_s.ctrl.pll_on_bit      = pwdata[pll_clock_pkg::PLL_ON_BIT];
			next_s.ctrl.lock_irq_enable = pwdata[pll_clock_pkg::LOCK_IE_BIT];
			next_s.ctrl.base_pll        = pwdata[pll_clock_pkg::BASE_PLL_BIT];
			next_s.ctrl.mod_xtal        = pwdata[pll_clock_pkg::MOD_XTAL_BIT];
			next_s.ctrl.clock_monitor_enable = pwdata[pll_clock_pkg::MON_EN_BIT];
			next_s.ctrl.no_limp_home_bit = pwdata[pll_clock_pkg::NO_LIMP_BIT];
			if (pwdata[pll_clock_pkg::PLL_ON_BIT] && !s.ctrl.pll_on_bit) begin
				next_s.stab_cnt = pll_clock_pkg::STAB_CYCLES;
			end
		end else if (wr && paddr == pll_clock_pkg::DIVIDE_OFFSET) begin
			next_s.ctrl.ref_div   = pwdata[pll_clock_pkg::REF_DIV_LSB +: 3];
			next_s.ctrl.mult      = pwdata[pll_clock_pkg::MULT_LSB +: 6];
			next_s.ctrl.slow_code = pwdata[pll_clock_pkg::SLOW_LSB +: 6];
		end else if (wr && paddr == pll_clock_pkg::STATUS_OFFSET) begin
			if (pwdata[pll_clock_pkg::LOCK_CHG_BIT]) begin
				next_s.lock_chg = 1'b0;
			end
		end

		// a change in the same cycle as the clear is kept
		if (next_s.lock != s.lock) begin
			next_s.lock_chg = 1'b1;                        // [RULE_14] [RULE_16]
		end
	end

	// ****************************************************************
	// registers
	// ****************************************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s <= '0;
			s.ctrl.auto_bw              <= pll_clock_pkg::AUTO_RESET;
			s.ctrl.acquisition_mode_bit <= pll_clock_pkg::FILTER_RESET;
			s.ctrl.pll_on_bit           <= pll_clock_pkg::PLL_ON_RESET;  // [RULE_19]
			s.ctrl.lock_irq_enable      <= pll_clock_pkg::LOCK_IE_RESET;
			s.ctrl.base_pll             <= pll_clock_pkg::BASE_PLL_RESET;
			s.ctrl.mod_xtal             <= pll_clock_pkg::MOD_XTAL_RESET;
			s.ctrl.clock_monitor_enable <= pll_clock_pkg::MON_EN_RESET;  // [RULE_19]
			s.ctrl.no_limp_home_bit     <= pll_clock_pkg::NO_LIMP_RESET; // [RULE_19]
			s.ctrl.ref_div              <= pll_clock_pkg::REF_DIV_RESET;
			s.ctrl.mult                 <= pll_clock_pkg::MULT_RESET;
			s.ctrl.slow_code            <= pll_clock_pkg::SLOW_RESET;
			s.stab_cnt                  <= pll_clock_pkg::STAB_CYCLES;
		end else if (ce) begin
			s <= next_s;
		end
	end

	// ****************************************************************
	// outputs
	// ****************************************************************
	assign prdata          = s.rdata;
	assign pslverr         = s.err & psel & penable;
	assign pready          = psel & penable;
	assign pll_run         = run;
	assign filter_tracking = s.ctrl.acquisition_mode_bit;            // [RULE_11]
	assign vco_multiplier  = s.ctrl.mult;                            // [RULE_03]
	assign lock_irq        = s.lock_chg & s.ctrl.lock_irq_enable;    // [RULE_14]
	assign ticks           = s.tk;

endmodule

// file: tb/vco_model.sv
`timescale 1ns/1ps
// ****************************************************************
// oscillator stand-in: square wave, half period in pclk cycles
// ****************************************************************
module vco_model (
	input  wire logic       pclk,
	input  wire logic       run,
	input  wire logic [3:0] half,
	output logic            vco
);
	logic [3:0] cnt;

	initial begin
		vco = 1'b0;
		cnt = 4'h0;
	end

	// stands low while disabled, no stale edges after stop
	always @(posedge pclk) begin
		if (!run) begin
			vco <= 1'b0;
			cnt <= 4'h0;
		end else if (cnt + 4'h1 >= half) begin
			vco <= ~vco;
			cnt <= 4'h0;
		end else begin
			cnt <= cnt + 4'h1;
		end
	end
endmodule

// file: tb/pll_clock_generator_props.sv
`timescale 1ns/1ps
module pll_clock_generator_checker (
	input wire logic                      pclk,
	input wire logic                      presetn,
	input wire logic                      ce,
	input wire logic                      psel,
	input wire logic                      penable,
	input wire logic                      pwrite,
	input wire logic                      stop_mode,
	input wire logic                      wait_mode,
	input wire logic                      can_clock_sel,
	input wire logic                      debug_clock_sel,
	input wire logic                      debug_tick,
	input wire logic                      pll_run,
	input wire logic                      filter_tracking,
	input wire logic [5:0]                vco_multiplier,
	input wire logic                      lock_irq,
	input wire pll_clock_pkg::clk_ticks_t ticks
);
	// ****************************************************************
	// properties
	// ****************************************************************
	logic wr;

	assign wr = psel && penable && pwrite;

	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	property p_wait_run;
		pll_run && wait_mode && !stop_mode && !wr |=> pll_run || stop_mode;
	endproperty
	a_wait_run: assert property (p_wait_run)
		else $error("pll halted during wait");

	property p_stop_off;
		stop_mode |-> !pll_run;
	endproperty
	a_stop_off: assert property (p_stop_off)
		else $error("pll running in stop");

	// only a write may drop the request: a status write clears the flag, a control write the enable
	property p_irq_hold;
		lock_irq && !wr |=> lock_irq;
	endproperty
	a_irq_hold: assert property (p_irq_hold)
		else $error("lock request lost without clear");

	property p_reset_vals;
		$rose(presetn) |-> pll_run == !stop_mode && vco_multiplier == 6'h00
			&& !lock_irq && !filter_tracking;
	endproperty
	a_reset_vals: assert property (p_reset_vals)
		else $error("wrong state after reset");

	property p_mult_hold;
		!wr |=> $stable(vco_multiplier);
	endproperty
	a_mult_hold: assert property (p_mult_hold)
		else $error("multiplier changed without write");

	property p_can_raw;
		(!can_clock_sel && ce) [*2] |-> ticks.can_clock;
	endproperty
	a_can_raw: assert property (p_can_raw)
		else $error("can tick missing on raw clock");

	property p_dbg_sel;
		!debug_clock_sel && ce ##1 !debug_clock_sel && ce
			|-> ticks.debug_clock == $past(debug_tick);
	endproperty
	a_dbg_sel: assert property (p_dbg_sel)
		else $error("debug tick not following debug input");

	property p_mod_src;
		ticks.module_clock |-> ticks.peripheral || ticks.crystal_derived_clock;
	endproperty
	a_mod_src: assert property (p_mod_src)
		else $error("module tick from no source");

	c_irq: cover property ($rose(lock_irq));
	c_track: cover property ($rose(filter_tracking));
	c_stop: cover property ($fell(pll_run));
endmodule

bind pll_clock_generator pll_clock_generator_checker u_checker (
	.pclk, .presetn, .ce, .psel, .penable, .pwrite, .stop_mode, .wait_mode,
	.can_clock_sel, .debug_clock_sel, .debug_tick, .pll_run,
	.filter_tracking, .vco_multiplier, .lock_irq, .ticks
);

// file: tb/test_pll_clock_generator.sv
`timescale 1ns/1ps
module test_pll_clock_generator;
	localparam logic [7:0] CTL = pll_clock_pkg::CTRL_OFFSET;
	localparam logic [7:0] DIV = pll_clock_pkg::DIVIDE_OFFSET;
	localparam logic [7:0] STA = pll_clock_pkg::STATUS_OFFSET;
	logic                      pclk, presetn, ce, psel, penable, pwrite;
	logic                      stop_mode, wait_mode, can_clock_sel;
	logic                      debug_clock_sel, debug_tick, vco_clock;
	logic                      pready, pslverr, pll_run, filter_tracking;
	logic                      lock_irq, rerr;
	logic [3:0]                half;
	logic [5:0]                vco_multiplier;
	logic [7:0]                paddr;
	logic [31:0]               pwdata, prdata, rdata;
	pll_clock_pkg::clk_ticks_t ticks;
	int                        miscompares, checked;

	pll_clock_generator u_pll_clock_generator (
		.pclk, .presetn, .ce, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr, .vco_clock, .stop_mode, .wait_mode,
		.can_clock_sel, .debug_clock_sel, .debug_tick, .pll_run,
		.filter_tracking, .vco_multiplier, .lock_irq, .ticks
	);
	vco_model u_vco_model (.pclk, .run(pll_run), .half, .vco(vco_clock));

	initial begin
		pclk = 1'b0;
		forever #12.5 pclk = ~pclk;
	end

	// ****************************************************************
	// shared tasks
	// ****************************************************************
	task automatic print_verdict;
		$display("checked %0d miscompares %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	task automatic chk(input string n, input logic [31:0] s, e);
		checked++;
		if (s !== e) begin
			miscompares++;
			$display("MISMATCH %s expected %h seen %h", n, e, s);
		end
	endtask

	// entered just after a rising edge; idle cycle after each transfer
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		int i;
		psel   <= 1'b1;
		pwrite <= w;
		paddr  <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		i = 0;
		do begin
			@(posedge pclk);
			i++;
		end while (pready !== 1'b1 && i < 20);
		if (i >= 20) begin
			chk("pready", 32'(pready), 32'h1);
			print_verdict();
		end
		rdata = prdata;
		rerr = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] m, e,
		input string n);
		apb(1'b0, a, 32'h0);
		chk(n, rdata & m, e);
	endtask

	task automatic tcount(input int idx, input int e, input string n);
		int c;
		c = 0;
		repeat (8) @(posedge pclk);
		repeat (64) begin
			@(negedge pclk);
			c += int'(ticks[idx]);
		end
		@(posedge pclk);
		chk(n, 32'(c), 32'(e));
	endtask

	task automatic wait_lock(input logic want);
		int i;
		i = 0;
		do begin
			apb(1'b0, STA, 32'h0);
			i++;
		end while (rdata[0] !== want && i < 200);
		chk("lock", 32'(rdata[0]), 32'(want));
		if (i >= 200) begin
			print_verdict();
		end
	endtask

	// ****************************************************************
	// scenarios
	// ****************************************************************
	task automatic t_reset;
		rd(CTL, 32'h000000FF, 32'h00000045, "ctrl");
		rd(DIV, 32'hFFFFFFFF, 32'h00010000, "divide");
		rd(STA, 32'h0000000F, 32'h00000000, "status");
		apb(1'b1, 8'h0C, 32'hFFFFFFFF);
		chk("err", 32'(rerr), 32'h1);
		rd(8'h0C, 32'hFFFFFFFF, 32'h00000000, "unmapped");
		$display("reset test done");
	endtask

	task automatic t_clocks;
		for (int d = 0; d < 8; d = d * 2 + 1) begin
			apb(1'b1, DIV, 32'h00010000 | 32'(d));
			tcount(1, 64 / (d + 1), "reference");
		end
		for (int k = 1; k <= 4; k = k * 2) begin
			apb(1'b1, DIV, 32'(k) << 16);
			tcount(5, 16 / k, "slow");
		end
		apb(1'b1, DIV, 32'h00003F00);
		chk("mult", 32'(vco_multiplier), 32'h3F);
		tcount(4, 32, "module periph");
		tcount(6, 32, "peripheral");
		tcount(9, 64, "base xtal");
		tcount(8, 64, "cpu");
		tcount(7, 32, "bus");
		apb(1'b1, CTL, 32'h00000065);
		tcount(4, 16, "module crystal");
		apb(1'b1, CTL, 32'h00000045);
		can_clock_sel <= 1'b0;
		tcount(3, 64, "can raw");
		can_clock_sel   <= 1'b1;
		debug_clock_sel <= 1'b0;
		tcount(2, 0, "debug idle");
		debug_tick <= 1'b1;
		tcount(2, 64, "debug tick");
		debug_clock_sel <= 1'b1;
		tcount(2, 32, "debug bus");
		$display("clock test done");
	endtask

	task automatic t_auto;
		half <= 4'h1;
		// change flag left over from the divider sweep
		apb(1'b1, STA, 32'h00000004);
		rd(STA, 32'h00000004, 32'h00000000, "chg clear");
		apb(1'b1, DIV, 32'h00010001);
		apb(1'b1, CTL, 32'h0000004D);
		wait_lock(1'b1);
		rd(STA, 32'h00000007, 32'h00000007, "status lock");
		chk("irq", 32'(lock_irq), 32'h1);
		chk("track", 32'(filter_tracking), 32'h1);
		tcount(0, 32, "feedback");
		// base clock moved to the pll only once locked
		apb(1'b1, CTL, 32'h0000005D);
		apb(1'b1, STA, 32'h00000004);
		chk("irq clear", 32'(lock_irq), 32'h0);
		half <= 4'h2;
		wait_lock(1'b0);
		chk("irq unlock", 32'(lock_irq), 32'h1);
		chk("acquisition", 32'(filter_tracking), 32'h0);
		apb(1'b1, CTL, 32'h0000004F);
		rd(CTL, 32'h00000002, 32'h00000000, "read only mode");
		apb(1'b1, STA, 32'h00000004);
		$display("auto test done");
	endtask

	task automatic t_manual;
		apb(1'b1, CTL, 32'h00000048);
		chk("pll off", 32'(pll_run), 32'h0);
		// acquisition bit clear before turning on
		apb(1'b1, CTL, 32'h0000004C);
		half <= 4'h1;
		chk("manual acquisition", 32'(filter_tracking), 32'h0);
		// settle in acquisition before asking for tracking
		repeat (64) @(posedge pclk);
		apb(1'b1, CTL, 32'h0000004E);
		chk("manual trk", 32'(filter_tracking), 32'h1);
		wait_lock(1'b1);
		chk("manual irq", 32'(lock_irq), 32'h1);
		apb(1'b1, STA, 32'h00000004);
		half <= 4'h2;
		wait_lock(1'b0);
		chk("no auto", 32'(filter_tracking), 32'h1);
		$display("manual test done");
	endtask

	task automatic t_power;
		wait_mode <= 1'b1;
		repeat (50) @(posedge pclk);
		chk("wait run", 32'(pll_run), 32'h1);
		wait_mode <= 1'b0;
		stop_mode <= 1'b1;
		@(negedge pclk);
		chk("stop", 32'(pll_run), 32'h0);
		@(posedge pclk);
		stop_mode <= 1'b0;
		repeat (2) @(posedge pclk);
		rd(CTL, 32'h00000004, 32'h00000000, "manual stop");
		apb(1'b1, CTL, 32'h00000045);
		stop_mode <= 1'b1;
		repeat (4) @(posedge pclk);
		stop_mode <= 1'b0;
		repeat (2) @(posedge pclk);
		rd(CTL, 32'h00000004, 32'h00000004, "auto stop");
		// base moves to the loop only once settled and locked
		half <= 4'h1;
		repeat (4100) @(posedge pclk);
		wait_lock(1'b1);
		rd(STA, 32'h00000008, 32'h00000008, "ready");
		apb(1'b1, CTL, 32'h00000055);
		tcount(9, 32, "base pll");
		$display("power test done");
	endtask

	initial begin
		miscompares = 0;
		checked = 0;
		presetn = 1'b0;
		ce = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h00000000;
		stop_mode = 1'b0;
		wait_mode = 1'b0;
		can_clock_sel = 1'b1;
		debug_clock_sel = 1'b1;
		debug_tick = 1'b0;
		half = 4'h1;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		t_reset();
		t_clocks();
		t_auto();
		t_manual();
		t_power();
		print_verdict();
	end
endmodule
